/* design/pll_shadow_regs.sv */
`timescale 1ns/10ps
`include "serial_port_pll_config_regs_params.svh"

module pll_shadow_regs
   import spll_types_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic softReset,
   input wire logic wrEn,
   input wire logic [1:0] wrIndex,
   input wire logic [7:0] wrData,
   input wire logic update,
   output logic [7:0] buffered [4],
   output pll_settings_t pllSettings
);

   localparam logic [7:0] MASK [4] = '{`SWALLOW_MASK, `FB_HIGH_MASK, `FB_LOW_MASK, `LOSS_CTRL_MASK};
   localparam logic [7:0] RESET_VAL [4] = '{`SWALLOW_RESET, `FB_HIGH_RESET, `FB_LOW_RESET, `LOSS_CTRL_RESET};

   logic [7:0] active [4];

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_reg
         wire logic hit = wrEn && (wrIndex == 2'(i));
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               buffered[i] <= RESET_VAL[i];
               active[i] <= RESET_VAL[i];
            end else if (softReset) begin
               buffered[i] <= RESET_VAL[i]; // [R5]
               active[i] <= RESET_VAL[i]; // [R5]
            end else begin
               if (hit) begin
                  buffered[i] <= wrData & MASK[i];
               end
               // Newest write wins when it lands with the strobe
               if (update) begin
                  active[i] <= hit ? (wrData & MASK[i]) : buffered[i];
               end
            end
         end
      end
   endgenerate

   assign pllSettings.swallowCount = active[0][5:0]; // [R10]
   assign pllSettings.feedbackCount = {active[1][4:0], active[2]}; // [R11] [R12]
   assign pllSettings.lossEnable = active[3][`LOSS_ENABLE_BIT]; // [R13]
   assign pllSettings.lossDelaySel = active[3][`LOSS_DELAY_LSB +: 2]; // [R14]

endmodule // pll_shadow_regs

/* design/ref_loss_arm.sv */
`timescale 1ns/10ps
`include "serial_port_pll_config_regs_params.svh"

module ref_loss_arm #(
   parameter int COUNT_WIDTH = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [1:0] delaySel,
   input wire logic lockDetect,
   input wire logic pfdTick,
   input wire logic refMissing,
   output logic lossArmed,
   output logic referenceLossDetect
);

   initial begin
      if (COUNT_WIDTH < 5) begin
         $error("COUNT_WIDTH too small for longest delay");
      end
   end

   logic lockSeen;
   logic [COUNT_WIDTH-1:0] cycles;
   wire logic [4:0] target = (delaySel == 2'h0) ? `LOSS_DELAY_0 :
                             (delaySel == 2'h1) ? `LOSS_DELAY_1 :
                             (delaySel == 2'h2) ? `LOSS_DELAY_2 : `LOSS_DELAY_3; // [R15]
   wire logic reached = (cycles + COUNT_WIDTH'(1)) >= COUNT_WIDTH'(target);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lockSeen <= 1'b0;
         cycles <= '0;
         lossArmed <= 1'b0;
      end else if (!enable) begin
         lockSeen <= 1'b0; // [R13]
         cycles <= '0;
         lossArmed <= 1'b0;
      end else begin
         if (lockDetect) begin
            lockSeen <= 1'b1;
         end
         // Count only once lock has first been seen
         if (lockSeen && !lossArmed && pfdTick) begin
            if (reached) begin
               lossArmed <= 1'b1; // [R14]
            end else begin
               cycles <= cycles + COUNT_WIDTH'(1);
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         referenceLossDetect <= 1'b0;
      end else begin
         referenceLossDetect <= lossArmed && refMissing; // [R13]
      end
   end

endmodule // ref_loss_arm

/* design/serial_port_pll_config_regs.sv */
// Summary of operation
// (R1) Config register writes act immediately
// (R2) Short format: eight-bit instruction phase
// (R3) Long instruction format after reset
// (R4) Long format: sixteen-bit instruction phase
// (R5) Soft-reset bit restores register defaults
// (R6) Soft-reset bit clears itself
// (R7) LSB first: LSB shifted, address increments
// (R8) MSB first default: address decrements
// (R9) Output disable: read data on data pin
// (R10) Swallow count six bits in 04h
// (R11) Feedback count high bits from 05h
// (R12) Feedback count low byte from 06h
// (R13) Loss detection runs only when enabled
// (R14) Wait selected detector cycles after lock
// (R15) Delay codes 3, 6, 12, 24
`timescale 1ns/10ps
`include "serial_port_pll_config_regs_params.svh"

module serial_port_pll_config_regs
   import spll_types_pkg::*;
#(
   parameter int ADDR_WIDTH = 13,
   parameter int COUNT_WIDTH = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdioIn,
   output logic sdioOut,
   output logic sdioOe,
   output logic serialOutPin,
   output logic serialOutOe,
   input wire logic lockDetect,
   input wire logic pfdTick,
   input wire logic refMissing,
   output pll_settings_t pllSettings,
   output logic lossArmed,
   output logic referenceLossDetect
);

   initial begin
      if (ADDR_WIDTH != 13) begin
         $error("ADDR_WIDTH must be 13 to match the long instruction");
      end
   end

   port_state_t state;
   logic sclkPrev;
   logic [15:0] instrShift;
   logic [3:0] bitCount;
   logic [1:0] byteMode;
   logic [1:0] bytesLeft;
   logic [12:0] addr;
   logic [7:0] dataShift;
   logic [7:0] outShift;
   logic outBit;
   logic [7:0] cfgReg;
   logic softReset;
   logic updatePulse;
   logic [7:0] buffered [4];

   // Pins are synchronous to clk, so edges come from a one-cycle history
   wire logic sclkRise = sclk && !sclkPrev && !csN;
   wire logic sclkFall = !sclk && sclkPrev && !csN;
   wire logic longMode = cfgReg[`CFG_LONG_INSTR_BIT];
   wire logic lsbFirst = cfgReg[`CFG_LSB_FIRST_BIT];
   wire logic outDisable = cfgReg[`CFG_OUT_PIN_DISABLE_BIT];

   wire logic [3:0] instrLast = longMode ? `LONG_INSTR_LAST : `SHORT_INSTR_LAST; // [R2] [R4]
   wire logic [15:0] shiftedInstr = lsbFirst ? {sdioIn, instrShift[15:1]} : {instrShift[14:0], sdioIn}; // [R7] [R8]
   wire logic [7:0] shortInstr = lsbFirst ? shiftedInstr[15:8] : shiftedInstr[7:0];
   wire logic instrRead = longMode ? shiftedInstr[15] : shortInstr[7];
   wire logic [1:0] instrCount = longMode ? shiftedInstr[14:13] : shortInstr[6:5];
   wire logic [12:0] instrAddr = longMode ? shiftedInstr[12:0] : {8'h00, shortInstr[4:0]};
   wire logic instrDone = sclkRise && (state == S_INSTR) && (bitCount == instrLast);

   wire logic [7:0] shiftedData = lsbFirst ? {sdioIn, dataShift[7:1]} : {dataShift[6:0], sdioIn}; // [R7] [R8]
   wire logic byteDone = sclkRise && (bitCount[2:0] == `BYTE_LAST);
   wire logic lastByte = (bytesLeft == 2'h0) && (byteMode != `STREAM_COUNT);
   wire logic [12:0] nextAddr = lsbFirst ? addr + 13'h0001 : addr - 13'h0001; // [R7] [R8]

   wire logic writeStrobe = byteDone && (state == S_WRITE);
   wire logic hitConfig = addr == `ADDR_SERIAL_PORT_CONFIG;
   wire logic hitUpdate = addr == `ADDR_UPDATE_REGISTERS;
   wire logic hitPll = addr[12:2] == `PLL_BANK_BASE;
   wire logic bankWrite = writeStrobe && hitPll && !softReset;

   function automatic logic [7:0] readMux(input logic [12:0] a);
      logic [7:0] value;
      value = 8'h00;
      if (a == `ADDR_SERIAL_PORT_CONFIG) begin
         value = cfgReg;
      end else if (a[12:2] == `PLL_BANK_BASE) begin
         value = buffered[a[1:0]];
      end
      return value;
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclkPrev <= 1'b0;
      end else begin
         sclkPrev <= sclk;
      end
   end

   // Serial transaction sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         instrShift <= 16'h0000;
         bitCount <= 4'h0;
         byteMode <= 2'h0;
         bytesLeft <= 2'h0;
         addr <= 13'h0000;
         dataShift <= 8'h00;
      end else if (csN) begin
         state <= S_IDLE;
         bitCount <= 4'h0;
      end else begin
         case (state)
            S_IDLE: begin
               state <= S_INSTR;
               bitCount <= 4'h0;
            end
            S_INSTR: begin
               if (sclkRise) begin
                  instrShift <= shiftedInstr;
                  bitCount <= bitCount + 4'h1;
               end
               if (instrDone) begin
                  state <= instrRead ? S_READ : S_WRITE;
                  addr <= instrAddr;
                  byteMode <= instrCount;
                  bytesLeft <= instrCount;
                  bitCount <= 4'h0;
               end
            end
            S_WRITE, S_READ: begin
               if (sclkRise) begin
                  dataShift <= shiftedData;
                  bitCount <= bitCount + 4'h1;
               end
               if (byteDone) begin
                  bitCount <= 4'h0;
                  addr <= nextAddr;
                  bytesLeft <= bytesLeft - 2'h1;
                  if (lastByte) begin
                     state <= S_HOLD;
                  end
               end
            end
            S_HOLD: begin
               state <= S_HOLD;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Read shifter: load on a rising edge, present on each falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outShift <= 8'h00;
         outBit <= 1'b0;
      end else if (instrDone && instrRead) begin
         outShift <= readMux(instrAddr);
      end else if (byteDone && (state == S_READ)) begin
         outShift <= readMux(nextAddr);
      end else if (sclkFall && (state == S_READ)) begin
         outBit <= lsbFirst ? outShift[0] : outShift[7]; // [R7] [R8]
         outShift <= lsbFirst ? {1'b0, outShift[7:1]} : {outShift[6:0], 1'b0};
      end
   end

   // Configuration register, applied without the update strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgReg <= `CFG_RESET; // [R3]
         softReset <= 1'b0;
         updatePulse <= 1'b0;
      end else begin
         softReset <= 1'b0;
         updatePulse <= writeStrobe && hitUpdate && shiftedData[`UPDATE_STROBE_BIT];
         if (writeStrobe && hitConfig) begin
            if (shiftedData[`CFG_SOFT_RESET_BIT]) begin
               // Defaults carry the bit at zero, so it never reads back set
               cfgReg <= `CFG_RESET; // [R5] [R6]
               softReset <= 1'b1; // [R5]
            end else begin
               cfgReg <= shiftedData & `CFG_WRITE_MASK; // [R1]
            end
         end
      end
   end

   // Shared read bit drives whichever pin is active
   assign sdioOut = outBit;
   assign serialOutPin = outBit;
   assign sdioOe = (state == S_READ) && outDisable; // [R9]
   assign serialOutOe = (state == S_READ) && !outDisable; // [R9]

   pll_shadow_regs u_shadow (
      .clk(clk),
      .rst(rst),
      .softReset(softReset),
      .wrEn(bankWrite),
      .wrIndex(addr[1:0]),
      .wrData(shiftedData),
      .update(updatePulse),
      .buffered(buffered),
      .pllSettings(pllSettings)
   );

   ref_loss_arm #(
      .COUNT_WIDTH(COUNT_WIDTH)
   ) u_loss (
      .clk(clk),
      .rst(rst),
      .enable(pllSettings.lossEnable),
      .delaySel(pllSettings.lossDelaySel),
      .lockDetect(lockDetect),
      .pfdTick(pfdTick),
      .refMissing(refMissing),
      .lossArmed(lossArmed),
      .referenceLossDetect(referenceLossDetect)
   );

endmodule // serial_port_pll_config_regs

/* design/serial_port_pll_config_regs_params.svh */
`ifndef SERIAL_PORT_PLL_CONFIG_REGS_PARAMS_SVH
`define SERIAL_PORT_PLL_CONFIG_REGS_PARAMS_SVH

// Register addresses
`define ADDR_SERIAL_PORT_CONFIG 13'h000
`define ADDR_PRESCALER_SWALLOW_COUNT 13'h004
`define ADDR_FEEDBACK_COUNT_HIGH 13'h005
`define ADDR_FEEDBACK_COUNT_LOW 13'h006
`define ADDR_REF_LOSS_CONTROL 13'h007
`define ADDR_UPDATE_REGISTERS 13'h05A
`define PLL_BANK_BASE 11'h001

// Serial port configuration fields
`define CFG_LONG_INSTR_BIT 4
`define CFG_SOFT_RESET_BIT 5
`define CFG_LSB_FIRST_BIT 6
`define CFG_OUT_PIN_DISABLE_BIT 7
`define CFG_RESET 8'h10
`define CFG_WRITE_MASK 8'hD0
`define UPDATE_STROBE_BIT 0

// PLL bank masks and reset values
`define SWALLOW_MASK 8'h3F
`define FB_HIGH_MASK 8'h1F
`define FB_LOW_MASK 8'hFF
`define LOSS_CTRL_MASK 8'h64
`define SWALLOW_RESET 8'h00
`define FB_HIGH_RESET 8'h00
`define FB_LOW_RESET 8'h00
`define LOSS_CTRL_RESET 8'h00
`define LOSS_ENABLE_BIT 2
`define LOSS_DELAY_LSB 5

// Instruction framing, last bit index
`define SHORT_INSTR_LAST 4'h7
`define LONG_INSTR_LAST 4'hF
`define BYTE_LAST 3'h7
`define STREAM_COUNT 2'h3

// Initial delay in detector cycles
`define LOSS_DELAY_0 5'h03
`define LOSS_DELAY_1 5'h06
`define LOSS_DELAY_2 5'h0C
`define LOSS_DELAY_3 5'h18

`endif

/* design/spll_types_pkg.sv */
package spll_types_pkg;

   typedef struct packed {
      logic [5:0] swallowCount;
      logic [12:0] feedbackCount;
      logic lossEnable;
      logic [1:0] lossDelaySel;
   } pll_settings_t;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_INSTR = 5'b00010,
      S_WRITE = 5'b00100,
      S_READ = 5'b01000,
      S_HOLD = 5'b10000
   } port_state_t;

endpackage

/* verif/host_model.sv */
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   input wire logic sdioOut,
   input wire logic sdioOe,
   input wire logic serialOutPin,
   input wire logic serialOutOe,
   output logic sclk,
   output logic csN,
   output logic sdioIn,
   output logic rdValid,
   output logic [7:0] rdData
);
   logic hostBit, hostDrives, lastBit, lsbFirst, outDis;
   int instLen;
   // Released line toggles, so a missing drive cannot pass
   assign sdioIn = sdioOe ? sdioOut : (hostDrives ? hostBit : ~lastBit);
   always @(posedge clk) lastBit <= sdioIn;
   initial begin
      {sclk, hostBit, hostDrives, lsbFirst, outDis, rdValid, lastBit} = '0;
      csN = 1'b1;
      rdData = 8'h00;
      instLen = 16;
   end
   task automatic bitx(input logic b, output logic r);
      hostBit <= b;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      r = outDis ? sdioIn : (serialOutOe ? serialOutPin : ~sdioIn);
      repeat (4) @(posedge clk);
   endtask
   task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [12:0] adr, input logic [23:0] wd);
      logic [15:0] ins;
      logic r;
      ins = instLen == 16 ? {rd, cnt, adr} : {8'h00, rd, cnt, adr[4:0]};
      csN <= 1'b0;
      hostDrives <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < instLen; i++) bitx(ins[lsbFirst ? i : instLen - 1 - i], r);
      for (int k = 0; k <= cnt; k++) begin
         hostDrives <= !rd;
         for (int i = 0; i < 8; i++) begin
            bitx(wd[8 * k + (lsbFirst ? i : 7 - i)], r);
            rdData[lsbFirst ? i : 7 - i] <= r;
         end
         rdValid <= rd;
         @(posedge clk);
         rdValid <= 1'b0;
      end
      repeat (4) @(posedge clk);
      csN <= 1'b1;
      hostDrives <= 1'b0;
      if (!rd && adr == 13'h0) begin
         instLen = wd[5] || wd[4] ? 16 : 8;
         lsbFirst = wd[6] && !wd[5];
         outDis = wd[7] && !wd[5];
      end
      repeat (8) @(posedge clk);
   endtask
endmodule // host_model

/* verif/serial_port_pll_config_regs_tb_top.sv */
`timescale 1ns/10ps
module serial_port_pll_config_regs_tb_top import spll_types_pkg::*;;
   logic clk, rst, sclk, csN, sdioIn, sdioOut, sdioOe, serialOutPin, serialOutOe;
   logic lockDetect, pfdTick, refMissing, lossArmed, referenceLossDetect, rdValid;
   logic [7:0] rdData, rnd;
   logic [7:0] expQ [$];
   pll_settings_t pllSettings;
   int nFail, numChecks, s, t;
   serial_port_pll_config_regs #(.ADDR_WIDTH(13), .COUNT_WIDTH(5)) serial_port_pll_config_regs_inst (
      .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
      .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .lockDetect(lockDetect), .pfdTick(pfdTick),
      .refMissing(refMissing), .pllSettings(pllSettings), .lossArmed(lossArmed),
      .referenceLossDetect(referenceLossDetect));
   host_model host_model_inst (.clk(clk), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOutPin(serialOutPin),
      .serialOutOe(serialOutOe), .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .rdValid(rdValid), .rdData(rdData));
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      numChecks++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] %0t read %h want %h", $time, g, e);
      end
   endtask
   task automatic chkS(input pll_settings_t g, input pll_settings_t e);
      numChecks++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] %0t settings %h want %h", $time, g, e);
      end
   endtask
   task automatic chkF(input logic g, input logic e);
      numChecks++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] %0t flag %b want %b", $time, g, e);
      end
   endtask
   task automatic rd(input logic [12:0] a, input logic [1:0] n, input logic [7:0] e0, input logic [7:0] e1);
      expQ.push_back(e0);
      if (n != 2'h0) expQ.push_back(e1);
      host_model_inst.xfer(1'b1, n, a, 24'h0);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host_model_inst.xfer(1'b0, 2'h0, a, {16'h0, d});
   endtask
   task automatic testDone();
      if (expQ.size() != 0) begin
         nFail++;
         $display("[FAIL] %0t reads missing", $time);
      end
      $display("checks %0d mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rdValid === 1'b1) chk8(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      nFail++;
      $display("[FAIL] %0t watchdog expired", $time);
      testDone();
   end
   initial begin
      rst = 1'b1;
      {lockDetect, pfdTick, refMissing} = '0;
      nFail = 0;
      numChecks = 0;
      void'($urandom(32'h7CFC9624));
      rnd = 8'($urandom());
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(13'h0, 2'h0, 8'h10, 8'h0);
      rd(13'h4, 2'h0, 8'h00, 8'h0);
      wr(13'h4, 8'hFF);
      rd(13'h4, 2'h0, 8'h3F, 8'h0);
      wr(13'h5, 8'hFF);
      rd(13'h5, 2'h0, 8'h1F, 8'h0);
      wr(13'h6, rnd);
      rd(13'h6, 2'h0, rnd, 8'h0);
      wr(13'h7, 8'hFF);
      rd(13'h7, 2'h0, 8'h64, 8'h0);
      wr(13'h2, 8'hFF);
      rd(13'h2, 2'h0, 8'h00, 8'h0);
      chkS(pllSettings, '0);
      wr(13'h5A, 8'h01);
      chkS(pllSettings, {6'h3F, 5'h1F, rnd, 1'b1, 2'h3});
      rd(13'h6, 2'h1, rnd, 8'h1F);
      $display("test bank done");
      wr(13'h0, 8'h00);
      rd(13'h4, 2'h0, 8'h3F, 8'h0);
      wr(13'h0, 8'h40);
      rd(13'h5, 2'h1, 8'h1F, rnd);
      wr(13'h0, 8'hC0);
      rd(13'h0, 2'h0, 8'hC0, 8'h0);
      wr(13'h0, 8'hE0);
      rd(13'h0, 2'h0, 8'h10, 8'h0);
      rd(13'h6, 2'h0, 8'h00, 8'h0);
      chkS(pllSettings, '0);
      $display("test modes done");
      for (s = 0; s < 4; s++) begin
         wr(13'h7, {1'b0, s[1:0], 5'h04});
         wr(13'h5A, 8'h01);
         lockDetect <= 1'b1;
         repeat (3) @(posedge clk);
         for (t = 1; t <= 24; t++) begin
            pfdTick <= 1'b1;
            @(posedge clk);
            pfdTick <= 1'b0;
            repeat (2) @(posedge clk);
            chkF(lossArmed, t >= (3 << s));
         end
         refMissing <= 1'b1;
         repeat (3) @(posedge clk);
         chkF(referenceLossDetect, 1'b1);
         refMissing <= 1'b0;
         wr(13'h7, 8'h00);
         wr(13'h5A, 8'h01);
         chkF(lossArmed, 1'b0);
         lockDetect <= 1'b0;
      end
      $display("test arming done");
      testDone();
   end
endmodule // serial_port_pll_config_regs_tb_top
bind serial_port_pll_config_regs spll_cfg_chk #(.ADDR_WIDTH(ADDR_WIDTH), .COUNT_WIDTH(COUNT_WIDTH)) spll_cfg_chk_inst (
   .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
   .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .lockDetect(lockDetect), .pfdTick(pfdTick),
   .refMissing(refMissing), .pllSettings(pllSettings), .lossArmed(lossArmed),
   .referenceLossDetect(referenceLossDetect));

/* verif/spll_cfg_chk.sv */
`timescale 1ns/10ps
module spll_cfg_chk
   import spll_types_pkg::*;
#(
   parameter int ADDR_WIDTH = 13,
   parameter int COUNT_WIDTH = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdioIn,
   input wire logic sdioOut,
   input wire logic sdioOe,
   input wire logic serialOutPin,
   input wire logic serialOutOe,
   input wire logic lockDetect,
   input wire logic pfdTick,
   input wire logic refMissing,
   input wire pll_settings_t pllSettings,
   input wire logic lossArmed,
   input wire logic referenceLossDetect
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   oe_excl_a: assert property (!(sdioOe && serialOutOe))
      else $error("both pins driven");
   pin_same_a: assert property (sdioOe || serialOutOe |-> sdioOut == serialOutPin)
      else $error("pins disagree");
   idle_quiet_a: assert property (csN && $past(csN) && $past(csN, 2) |-> !sdioOe && !serialOutOe)
      else $error("pin driven while idle");
   settings_hold_a: assert property (csN && $past(csN) && $past(csN, 2) |-> $stable(pllSettings))
      else $error("settings moved while idle");
   arm_enable_a: assert property ($rose(lossArmed) |-> pllSettings.lossEnable)
      else $error("armed while disabled");
   arm_clear_a: assert property (!pllSettings.lossEnable |=> !lossArmed)
      else $error("arm not cleared");
   arm_tick_a: assert property ($rose(lossArmed) |-> $past(pfdTick) || $past(pfdTick, 2))
      else $error("armed without tick");
   lor_follow_a: assert property (1'b1 |=> referenceLossDetect == ($past(lossArmed) && $past(refMissing)))
      else $error("loss flag wrong");
   reset_clean_a: assert property ($past(rst) |-> pllSettings == '0 && !lossArmed)
      else $error("reset state wrong");
   cover property (sdioOe);
   cover property (serialOutOe);
   cover property ($rose(lossArmed));
endmodule // spll_cfg_chk
